// [test/ebc_checker.sv]
// Assertion checker for the external bus controller pins and register bus
`timescale 1ns/10ps
module ebc_checker
(
   input wire aclk,
   input wire aresetn,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire [7:0] port3_oe,
   input wire [7:0] port4_oe,
   input wire [7:0] port5_in,
   input wire [7:0] port5_out,
   input wire [7:0] port5_oe,
   input wire half_rate_clock_output
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire rd_on = port5_oe[3] && !port5_out[3];
   wire wr_on = port5_oe[2] && !port5_out[2];
   sequence s_rd_wait;
      (rd_on && !port5_in[6]) [*3];
   endsequence
   sequence s_rd_go;
      (rd_on && port5_in[6]) [*3];
   endsequence
   property p_clk_toggle;
      $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3) |-> half_rate_clock_output != $past(half_rate_clock_output);
   endproperty
   property p_rd_wr_excl;
      rd_on |-> !wr_on;
   endproperty
   property p_bytesel_write;
      port5_oe[5] && !port5_out[5] |-> port5_out[3];
   endproperty
   property p_fetch_no_write;
      port5_oe[1] && port5_out[1] |-> !wr_on;
   endproperty
   property p_ready_hold;
      s_rd_wait |=> rd_on;
   endproperty
   property p_ready_release;
      s_rd_go |=> !rd_on;
   endproperty
   property p_write_drive;
      wr_on |-> port3_oe == 8'hFF;
   endproperty
   property p_read_release;
      rd_on |-> port3_oe == 8'h00 && port4_oe == 8'h00;
   endproperty
   property p_rd_latency;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_clk_toggle: assert property (p_clk_toggle) else $error("clock output did not toggle");
   a_rd_wr_excl: assert property (p_rd_wr_excl) else $error("read and write strobes both low");
   a_bytesel_write: assert property (p_bytesel_write) else $error("byte select low in a read");
   a_fetch_no_write: assert property (p_fetch_no_write) else $error("fetch indicator in a write");
   a_ready_hold: assert property (p_ready_hold) else $error("read ended while ready low");
   a_ready_release: assert property (p_ready_release) else $error("read stretched with ready high");
   a_write_drive: assert property (p_write_drive) else $error("write data not driven");
   a_read_release: assert property (p_read_release) else $error("bus driven during read");
   a_rd_latency: assert property (p_rd_latency) else $error("read data late");
endmodule
bind ebc_top ebc_checker u_ebc_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .port3_oe(port3_oe), .port4_oe(port4_oe),
   .port5_in(port5_in), .port5_out(port5_out), .port5_oe(port5_oe), .half_rate_clock_output(half_rate_clock_output));

// [test/ebc_ext_mem.sv]
// External memory model with wait states on the multiplexed bus
`timescale 1ns/10ps
module ebc_ext_mem
(
   input wire aclk,
   input wire valid_mode,
   input wire w16,
   input wire [2:0] waits,
   input wire [7:0] port3_out,
   input wire [7:0] port4_out,
   input wire [7:0] port5_out,
   input wire [7:0] port5_oe,
   output wire [7:0] p3_drv,
   output wire [7:0] p4_drv,
   output wire ready_pin
);
   logic [7:0] mem [0:65535];
   logic [15:0] lat = 16'h0000;
   logic prev_s = 1'h0;
   logic [2:0] cnt = 3'h0;
   wire rd_on = port5_oe[3] && !port5_out[3];
   wire fall = prev_s && !port5_out[0];
   // Wait count starts as the address phase appears on the pins, in either strobe mode
   wire start = valid_mode ? fall : (!prev_s && port5_out[0]);
   wire [15:0] ev = {lat[15:1], 1'h0};
   // Released lines rest at the pull-up level
   assign p3_drv = rd_on ? mem[w16 ? ev : lat] : 8'hFF;
   assign p4_drv = rd_on ? mem[ev | 16'h0001] : 8'hFF;
   assign ready_pin = cnt == 3'h0;
   always @(posedge aclk)
   begin
      prev_s <= port5_out[0];
      cnt <= start ? waits : ((cnt != 3'h0) ? cnt - 3'h1 : 3'h0);
      // Latch pulse is transparent while high; valid level is taken at its falling edge
      if (valid_mode ? fall : port5_out[0])
         lat <= {port4_out, port3_out};
      if (port5_oe[2] && !port5_out[2])
      begin
         mem[w16 ? ev : lat] <= port3_out;
         if (w16)
            mem[ev | 16'h0001] <= port4_out;
      end
   end
endmodule

// [test/tb_external_bus_control.sv]
// Self-checking testbench for the external bus controller
`timescale 1ns/10ps
`include "ebc_consts.vh"
module tb_external_bus_control;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ebc_note_t;
   logic aclk = 1'h0, aresetn = 1'h0, xsel = 1'h1, w16 = 1'h0, valid_mode = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, last_rd = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [2:0] waits = 3'h0;
   logic [1:0] last_bresp = 2'h0;
   logic [15:0] ia [4] = '{16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000};
   logic [7:0] cfg_tab [5] = '{8'h22, 8'h23, 8'h26, 8'h27, 8'h20};
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, half_rate_clock_output, ready_pin;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] port3_in, port3_out, port3_oe, port4_in, port4_out, port4_oe, port5_in, port5_out, port5_oe, p3_drv, p4_drv;
   ebc_note_t q[$];
   ebc_note_t nt;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   int cnt [4] = '{0, 0, 0, 0};
   int base [4] = '{0, 0, 0, 0};
   assign port3_in = (port3_oe & port3_out) | (~port3_oe & p3_drv);
   assign port4_in = (port4_oe & port4_out) | (~port4_oe & p4_drv);
   assign port5_in = (port5_oe & port5_out) | (~port5_oe & {w16, ready_pin, 6'h3F});
   ebc_top u_ebc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .external_access_select(xsel), .port3_in(port3_in), .port3_out(port3_out), .port3_oe(port3_oe),
      .port4_in(port4_in), .port4_out(port4_out), .port4_oe(port4_oe), .port5_in(port5_in), .port5_out(port5_out),
      .port5_oe(port5_oe), .half_rate_clock_output(half_rate_clock_output));
   ebc_ext_mem u_ebc_ext_mem (.aclk(aclk), .valid_mode(valid_mode), .w16(w16), .waits(waits),
      .port3_out(port3_out), .port4_out(port4_out), .port5_out(port5_out), .port5_oe(port5_oe),
      .p3_drv(p3_drv), .p4_drv(p4_drv), .ready_pin(ready_pin));
   initial
   begin
      forever
         #4 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expd);
      total_checks++;
      if (seen !== expd)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, expd, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Counts strobe cycles (read, write, byte select, fetch) and compares noted read results
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      cnt[0] <= cnt[0] + ((port5_oe[3] && !port5_out[3]) ? 1 : 0);
      cnt[1] <= cnt[1] + ((port5_oe[2] && !port5_out[2]) ? 1 : 0);
      cnt[2] <= cnt[2] + ((port5_oe[5] && !port5_out[5]) ? 1 : 0);
      cnt[3] <= cnt[3] + ((port5_oe[1] && port5_out[1]) ? 1 : 0);
      if (s_axi_rvalid && s_axi_rready)
      begin
         nt = q.pop_front();
         if (nt.m != 32'h0)
         begin
            chk("rdata", s_axi_rdata & nt.m, nt.d & nt.m);
            chk("rresp", {30'h0, s_axi_rresp}, {30'h0, nt.r});
         end
      end
      if (cyc == 20000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
         begin
            last_bresp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
      q.push_back('{d, m, r});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
         begin
            last_rd = s_axi_rdata;
            s_axi_rready <= 1'h0;
            break;
         end
      end
   endtask
   task automatic ext_op(input logic [15:0] a, input logic [15:0] d, input logic [2:0] c);
      int i;
      axi_wr(`EBC_REG_ADDR, {16'h0000, a});
      axi_wr(`EBC_REG_WDATA, {16'h0000, d});
      base = cnt;
      axi_wr(`EBC_REG_CMD, {29'h0, c});
      last_rd = 32'h1;
      for (i = 0; i < 100 && last_rd[0]; i++)
         axi_rd(`EBC_REG_STATUS, 32'h0, 32'h0, 2'h0);
      chk("busy", last_rd & 32'h1, 32'h0);
   endtask
   function automatic logic [31:0] seen(input int k);
      return (cnt[k] != base[k]) ? 32'h1 : 32'h0;
   endfunction
   task automatic do_reset(input logic e);
      aresetn <= 1'h0;
      xsel <= e;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
   endtask
   initial
   begin
      logic [15:0] a;
      logic [15:0] d;
      int k;
      void'($urandom(65));
      do_reset(1'h1);
      axi_rd(`EBC_REG_CONFIG, {26'h0, `EBC_CFG_RESET}, 32'hFFFFFFFF, `EBC_RESP_OKAY);
      axi_rd(`EBC_REG_GPIO_OUT, 32'h00FFFFFF, 32'h00FFFFFF, `EBC_RESP_OKAY);
      axi_rd(`EBC_REG_STATUS, 32'h8, 32'h9, `EBC_RESP_OKAY);
      axi_rd(8'h40, 32'h0, 32'hFFFFFFFF, `EBC_RESP_SLVERR);
      axi_wr(8'h40, 32'h0);
      chk("bresp", {30'h0, last_bresp}, {30'h0, `EBC_RESP_SLVERR});
      $display("test reset done");
      for (k = 0; k < 5; k++)
      begin
         axi_wr(`EBC_REG_CONFIG, {24'h0, cfg_tab[k]});
         valid_mode <= cfg_tab[k][0];
         w16 <= (k == 4) ? 1'h0 : ((k < 2) ? 1'h1 : 1'($urandom));
         waits <= {1'(k % 2), 1'($urandom), 1'h0};
         a = 16'h8000 | (16'($urandom) & 16'h3FFE);
         d = 16'($urandom);
         ext_op(a, d, 3'h1);
         ext_op(a, 16'h0000, 3'h0);
         chk("ext_read", seen(0), 32'h1);
         axi_rd(`EBC_REG_RDATA, {16'h0, d}, 32'hFFFF, `EBC_RESP_OKAY);
         axi_rd(`EBC_REG_STATUS, {29'h0, w16, 2'h0}, 32'h4, `EBC_RESP_OKAY);
      end
      $display("test roundtrip done");
      for (k = 0; k < 4; k++)
      begin
         ext_op(ia[k], 16'h0000, 3'h0);
         chk("ext_read", seen(0), (k == 1 || k == 2) ? 32'h0 : 32'h1);
         axi_rd(`EBC_REG_STATUS, (k == 1 || k == 2) ? 32'h2 : 32'h0, 32'h2, `EBC_RESP_OKAY);
         if (k == 1 || k == 2)
            axi_rd(`EBC_REG_RDATA, 32'hFFFF, 32'hFFFF, `EBC_RESP_OKAY);
      end
      ext_op(16'h9000, 16'h0000, 3'h2);
      chk("fetch", seen(3), 32'h1);
      ext_op(16'h9000, 16'h0000, 3'h0);
      chk("fetch", seen(3), 32'h0);
      $display("test internal and fetch done");
      w16 <= 1'h0;
      do_reset(1'h0);
      ext_op(16'h3000, 16'h0000, 3'h0);
      chk("ext_read", seen(0), 32'h1);
      axi_rd(`EBC_REG_STATUS, 32'h0, 32'hA, `EBC_RESP_OKAY);
      $display("test external only done");
      w16 <= 1'h1;
      for (k = 0; k < 6; k++)
      begin
         axi_wr(`EBC_REG_CONFIG, {24'h0, 8'h22 | ((k < 2) ? 8'h00 : ((k < 4) ? 8'h08 : 8'h10))});
         ext_op(16'h8001 - 16'(k % 2), 16'hA55A, 3'h5);
         chk("bytesel", seen(2), (k % 2 == 0) ? 32'h1 : 32'h0);
         chk("write_strobe", seen(1), (k == 4) ? 32'h0 : 32'h1);
      end
      ext_op(16'h8001, 16'h0000, 3'h4);
      chk("bytesel", seen(2), 32'h0);
      $display("test byte select done");
      axi_wr(`EBC_REG_GPIO_OUT, 32'h00FFFF5A);
      repeat (2) @(posedge aclk);
      chk("p3_oe", {24'h0, port3_oe}, 32'hA5);
      axi_wr(`EBC_REG_CONFIG, 32'h0);
      axi_wr(`EBC_REG_GPIO_DIR, 32'h00010000);
      axi_wr(`EBC_REG_GPIO_OUT, 32'h00FEFFFF);
      repeat (2) @(posedge aclk);
      chk("p5_gpio", {30'h0, port5_oe[0], port5_out[0]}, 32'h2);
      $display("test port io done");
      end_sim();
   end
endmodule

// [verilog/ebc_consts.vh]
// Constants for the external bus control block
`ifndef EBC_CONSTS_VH
`define EBC_CONSTS_VH

// Register byte offsets
`define EBC_REG_CONFIG 8'h00
`define EBC_REG_ADDR 8'h04
`define EBC_REG_WDATA 8'h08
`define EBC_REG_CMD 8'h0C
`define EBC_REG_STATUS 8'h10
`define EBC_REG_RDATA 8'h14
`define EBC_REG_GPIO_OUT 8'h18
`define EBC_REG_GPIO_DIR 8'h1C
`define EBC_REG_GPIO_IN 8'h20

// Chip configuration word fields
`define EBC_CFG_VALID 0
`define EBC_CFG_WID_A 1
`define EBC_CFG_WID_B 2
`define EBC_CFG_ODD 3
`define EBC_CFG_EVEN 4
`define EBC_CFG_BUS 5
`define EBC_CFG_RESET 6'h20

// Command fields
`define EBC_CMD_WRITE 0
`define EBC_CMD_FETCH 1
`define EBC_CMD_BYTE 2

// Status fields
`define EBC_ST_BUSY 0
`define EBC_ST_INT 1
`define EBC_ST_W16 2
`define EBC_ST_XSEL 3

// Port 5 pin positions
`define EBC_P5_STROBE 0
`define EBC_P5_FETCH 1
`define EBC_P5_WRITE 2
`define EBC_P5_READ 3
`define EBC_P5_BYTESEL 5
`define EBC_P5_READY 6
`define EBC_P5_WIDTH 7
`define EBC_P5_BUS_OUT 8'h2F
`define EBC_P5_BUS_MASK 8'hEF

// On-chip program range and blank read value
`define EBC_INT_LO 16'h2000
`define EBC_INT_HI 16'h5FFF
`define EBC_BLANK 16'hFFFF

// Bus cycle states
`define EBC_S_IDLE 2'h0
`define EBC_S_ADDR 2'h1
`define EBC_S_DATA 2'h2
`define EBC_S_DONE 2'h3

`define EBC_RESP_OKAY 2'h0
`define EBC_RESP_SLVERR 2'h2

`endif

// [verilog/ebc_top.v]
// External multiplexed bus controller with AXI4-Lite register access
`timescale 1ns/10ps
`include "ebc_consts.vh"

// Function
// (RULE1) The address strobe works either as an address-latch pulse or as an address-valid level, set by configuration.
// (RULE2) In address-valid mode the strobe returns high at the end of every bus cycle.
// (RULE3) The strobe is active only during external accesses and its pin is plain port I/O otherwise; the code frees it only with config bit 5 clear.
// (RULE4) The byte-select pin is an upper-byte enable or an odd-byte write strobe, set by configuration.
// (RULE5) The byte-select pin is driven active only in external write cycles.
// (RULE6) With configuration bits 1 and 2 both set, the width input pin decides each cycle's width.
// (RULE7) The width pin low gives an 8-bit cycle and high a 16-bit cycle, and the cycle runs at that width.
// (RULE8) The clock output runs at half the input clock rate with 50% duty.
// (RULE9) With the latched external-access input low, every access goes to the external bus.
// (RULE10) With it high, addresses 2000H to 5FFFH are served on chip and the rest go external.
// (RULE11) The fetch indicator is high through an external instruction fetch cycle and low otherwise.
// (RULE12) Ports 3 and 4 carry address and data with strong drive in bus mode and are open-drain as port I/O.
// (RULE13) Seven port 5 pins carry bus control and each stays port I/O when its bus use is off; the code switches all seven together on config bit 5.
// (RULE14) The read strobe is low only during external read cycles.
// (RULE15) The ready input held low stretches a cycle until a rising clock-output edge sees it high.
// (RULE16) The write strobe is low on every external write, or in even mode only for even-byte writes.
// (RULE17) The address is on the bus while the strobe is active and the same lines carry data afterwards; the code keeps the valid-mode strobe low in data.
module ebc_top
(
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire external_access_select,
   input wire [7:0] port3_in,
   output reg [7:0] port3_out,
   output reg [7:0] port3_oe,
   input wire [7:0] port4_in,
   output reg [7:0] port4_out,
   output reg [7:0] port4_oe,
   input wire [7:0] port5_in,
   output reg [7:0] port5_out,
   output reg [7:0] port5_oe,
   output reg half_rate_clock_output
);

   reg [5:0] chip_configuration_word;
   reg [15:0] addr_reg;
   reg [15:0] wdata_reg;
   reg [15:0] rdata_reg;
   reg [23:0] gpio_out;
   reg [7:0] gpio_dir;
   reg [1:0] state;
   reg busy;
   reg acc_write;
   reg acc_fetch;
   reg acc_byte;
   reg second;
   reg [15:0] cur_addr;
   reg last_int;
   reg last_w16;
   reg xsel_latched;
   reg rst_seen;
   reg have_aw;
   reg have_w;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [31:0] rd_word;
   reg rd_ok;
   reg [7:0] next_p3_out;
   reg [7:0] next_p3_oe;
   reg [7:0] next_p4_out;
   reg [7:0] next_p4_oe;
   reg [7:0] bus_p5;
   wire [23:0] wmask;
   wire [7:0] wa;
   wire [7:0] ra;
   wire tick;
   wire dynamic;
   wire width_now;
   wire ready_in;
   wire internal;
   wire do_write;
   wire hi_byte;
   wire odd_mode;
   wire [7:0] next_p5_out;
   wire [7:0] next_p5_oe;

   assign wmask = {{8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wa = {awaddr_q[7:2], 2'b00};
   assign ra = {s_axi_araddr[7:2], 2'b00};
   assign do_write = have_aw && have_w && !s_axi_bvalid;
   // Next aclk edge is a rising edge of the clock output
   assign tick = !half_rate_clock_output;
   assign dynamic = chip_configuration_word[`EBC_CFG_WID_A] && chip_configuration_word[`EBC_CFG_WID_B]; // see (RULE6)
   assign width_now = dynamic ? port5_in[`EBC_P5_WIDTH] : chip_configuration_word[`EBC_CFG_WID_A]; // see (RULE7)
   assign ready_in = port5_in[`EBC_P5_READY];
   assign internal = xsel_latched && (cur_addr >= `EBC_INT_LO) && (cur_addr <= `EBC_INT_HI); // see (RULE9) (RULE10)
   assign hi_byte = cur_addr[0] || (!acc_byte && !second && width_now);
   assign odd_mode = chip_configuration_word[`EBC_CFG_ODD];

   // Read decode
   always @*
   begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      if (ra == `EBC_REG_CONFIG)
         rd_word = {26'h0000000, chip_configuration_word};
      else if (ra == `EBC_REG_ADDR)
         rd_word = {16'h0000, addr_reg};
      else if (ra == `EBC_REG_WDATA)
         rd_word = {16'h0000, wdata_reg};
      else if (ra == `EBC_REG_CMD)
         rd_word = {29'h00000000, acc_byte, acc_fetch, acc_write};
      else if (ra == `EBC_REG_STATUS)
         rd_word = {28'h0000000, xsel_latched, last_w16, last_int, busy};
      else if (ra == `EBC_REG_RDATA)
         rd_word = {16'h0000, rdata_reg};
      else if (ra == `EBC_REG_GPIO_OUT)
         rd_word = {8'h00, gpio_out};
      else if (ra == `EBC_REG_GPIO_DIR)
         rd_word = {8'h00, gpio_dir, 16'h0000};
      else if (ra == `EBC_REG_GPIO_IN)
         rd_word = {8'h00, port5_in, port4_in, port3_in};
      else
         rd_ok = 1'b0;
   end

   // AXI4-Lite slave and register file
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EBC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `EBC_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         have_aw <= 1'b0;
         have_w <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         chip_configuration_word <= `EBC_CFG_RESET;
         addr_reg <= 16'h0000;
         wdata_reg <= 16'h0000;
         gpio_out <= 24'hFFFFFF;
         gpio_dir <= 8'h00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            have_aw <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!have_aw && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            have_w <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (!have_w && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         if (do_write)
         begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `EBC_RESP_OKAY;
            if (wa == `EBC_REG_CONFIG)
               chip_configuration_word <= (chip_configuration_word & ~wmask[5:0]) | (wdata_q[5:0] & wmask[5:0]);
            else if (wa == `EBC_REG_ADDR)
               addr_reg <= (addr_reg & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
            else if (wa == `EBC_REG_WDATA)
               wdata_reg <= (wdata_reg & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
            else if (wa == `EBC_REG_GPIO_OUT)
               gpio_out <= (gpio_out & ~wmask) | (wdata_q[23:0] & wmask);
            else if (wa == `EBC_REG_GPIO_DIR)
               gpio_dir <= wstrb_q[2] ? wdata_q[23:16] : gpio_dir;
            else if (wa == `EBC_REG_CMD || wa == `EBC_REG_STATUS || wa == `EBC_REG_RDATA || wa == `EBC_REG_GPIO_IN)
               s_axi_bresp <= `EBC_RESP_OKAY;
            else
               s_axi_bresp <= `EBC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `EBC_RESP_OKAY : `EBC_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
      end
   end

   // Bus cycle sequencer
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         half_rate_clock_output <= 1'b0;
         state <= `EBC_S_IDLE;
         busy <= 1'b0;
         acc_write <= 1'b0;
         acc_fetch <= 1'b0;
         acc_byte <= 1'b0;
         second <= 1'b0;
         cur_addr <= 16'h0000;
         last_int <= 1'b0;
         last_w16 <= 1'b0;
         rdata_reg <= 16'h0000;
         xsel_latched <= 1'b0;
         rst_seen <= 1'b0;
      end
      else
      begin
         half_rate_clock_output <= !half_rate_clock_output; // see (RULE8)
         if (!rst_seen)
         begin
            rst_seen <= 1'b1;
            xsel_latched <= external_access_select; // see (RULE9)
         end
         if (do_write && wa == `EBC_REG_CMD && wstrb_q[0] && !busy)
         begin
            busy <= 1'b1;
            acc_write <= wdata_q[`EBC_CMD_WRITE];
            acc_fetch <= wdata_q[`EBC_CMD_FETCH];
            acc_byte <= wdata_q[`EBC_CMD_BYTE];
            second <= 1'b0;
            cur_addr <= addr_reg;
         end
         case (state)
            `EBC_S_IDLE:
            begin
               if (busy && rst_seen && internal)
               begin
                  busy <= 1'b0;
                  last_int <= 1'b1; // see (RULE10)
                  if (!acc_write)
                     rdata_reg <= `EBC_BLANK;
               end
               else if (busy && rst_seen && tick)
               begin
                  last_int <= 1'b0;
                  state <= `EBC_S_ADDR;
               end
            end
            `EBC_S_ADDR:
               if (tick)
                  state <= `EBC_S_DATA;
            `EBC_S_DATA:
               if (tick && ready_in) // see (RULE15)
               begin
                  state <= `EBC_S_DONE;
                  last_w16 <= width_now; // see (RULE7)
                  if (!acc_write && width_now)
                     rdata_reg <= {port4_in, port3_in};
                  else if (!acc_write && cur_addr[0])
                     rdata_reg[15:8] <= port3_in;
                  else if (!acc_write)
                     rdata_reg[7:0] <= port3_in;
               end
            default:
               if (tick)
               begin
                  if (!acc_byte && !last_w16 && !second)
                  begin
                     second <= 1'b1;
                     cur_addr <= cur_addr | 16'h0001;
                     state <= `EBC_S_ADDR;
                  end
                  else
                  begin
                     busy <= 1'b0;
                     state <= `EBC_S_IDLE;
                  end
               end
         endcase
      end
   end

   // Bus control levels on port 5
   always @*
   begin
      bus_p5 = `EBC_P5_BUS_OUT;
      if (chip_configuration_word[`EBC_CFG_VALID])
         bus_p5[`EBC_P5_STROBE] = !(state == `EBC_S_ADDR || state == `EBC_S_DATA); // see (RULE1) (RULE2) (RULE3)
      else
         bus_p5[`EBC_P5_STROBE] = (state == `EBC_S_ADDR); // see (RULE1) (RULE3)
      bus_p5[`EBC_P5_FETCH] = acc_fetch && !acc_write && (state != `EBC_S_IDLE); // see (RULE11)
      bus_p5[`EBC_P5_READ] = !(state == `EBC_S_DATA && !acc_write); // see (RULE14)
      if (chip_configuration_word[`EBC_CFG_EVEN])
         bus_p5[`EBC_P5_WRITE] = !(state == `EBC_S_DATA && acc_write && !cur_addr[0]); // see (RULE16)
      else
         bus_p5[`EBC_P5_WRITE] = !(state == `EBC_S_DATA && acc_write); // see (RULE16)
      if (odd_mode)
         bus_p5[`EBC_P5_BYTESEL] = !(state == `EBC_S_DATA && acc_write && hi_byte); // see (RULE4) (RULE5)
      else
         bus_p5[`EBC_P5_BYTESEL] = !(state != `EBC_S_IDLE && state != `EBC_S_DONE && acc_write && hi_byte); // see (RULE4) (RULE5)
   end

   // Port 5 pins fall back to port I/O when the bus is off
   assign next_p5_out = chip_configuration_word[`EBC_CFG_BUS] ?
      ((bus_p5 & `EBC_P5_BUS_MASK) | (gpio_out[23:16] & ~`EBC_P5_BUS_MASK)) : gpio_out[23:16]; // see (RULE13)
   assign next_p5_oe = chip_configuration_word[`EBC_CFG_BUS] ?
      ((`EBC_P5_BUS_OUT & `EBC_P5_BUS_MASK) | (gpio_dir & ~`EBC_P5_BUS_MASK)) : gpio_dir; // see (RULE13)

   // Address and data on ports 3 and 4
   always @*
   begin
      next_p3_out = 8'h00;
      next_p4_out = 8'h00;
      next_p3_oe = ~gpio_out[7:0]; // see (RULE12)
      next_p4_oe = ~gpio_out[15:8]; // see (RULE12)
      if (state == `EBC_S_ADDR)
      begin
         next_p3_out = cur_addr[7:0]; // see (RULE17)
         next_p4_out = cur_addr[15:8];
         next_p3_oe = 8'hFF; // see (RULE12)
         next_p4_oe = 8'hFF;
      end
      else if ((state == `EBC_S_DATA || state == `EBC_S_DONE) && acc_write)
      begin
         next_p3_out = cur_addr[0] ? wdata_reg[15:8] : wdata_reg[7:0]; // see (RULE17)
         next_p4_out = wdata_reg[15:8];
         next_p3_oe = 8'hFF;
         next_p4_oe = 8'hFF;
      end
      else if (state == `EBC_S_DATA || state == `EBC_S_DONE)
      begin
         next_p3_oe = 8'h00; // see (RULE17)
         next_p4_oe = 8'h00;
      end
   end

   // Pin registers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         port3_out <= 8'h00;
         port3_oe <= 8'h00;
         port4_out <= 8'h00;
         port4_oe <= 8'h00;
         port5_out <= 8'h00;
         port5_oe <= 8'h00;
      end
      else
      begin
         port3_out <= next_p3_out;
         port3_oe <= next_p3_oe;
         port4_out <= next_p4_out;
         port4_oe <= next_p4_oe;
         port5_out <= next_p5_out;
         port5_oe <= next_p5_oe;
      end
   end

endmodule
